// file: spindle_ctrl_map.vh
`ifndef SPINDLE_CTRL_MAP_VH
`define SPINDLE_CTRL_MAP_VH
// ==========================================================
// register byte offsets
`define OFS_SPEED_COUNT 8'h00
`define OFS_DELAY 8'h04
`define OFS_LOCK_WIN 8'h08
`define OFS_STATUS 8'h10
`define OFS_SPEED_ERR 8'h14
`define OFS_INT_STATUS 8'h18
`define OFS_INT_CLEAR 8'h1C
`define OFS_INT_ENABLE 8'h20
// ==========================================================
// speed reference, target speed and register reset values
`define REF_HZ 32'd2000000
`define TARGET_RPM 32'd3600
`define SEC_PER_MIN 32'd60
`define DELAY_RST 16'h0000
`define LOCK_WIN_RST 16'h0037
`define INT_ENABLE_RST 5'h00
// ==========================================================
// commutation-to-revolution dividers
`define DIV_8POLE 5'd24
`define DIV_4POLE 5'd12
// ==========================================================
// interrupt status bit positions
`define IRQ_LOCK_GAIN 0
`define IRQ_LOCK_LOSS 1
`define IRQ_FAULT 2
`define IRQ_REV 3
`define IRQ_BRAKE 4
`define IRQ_W 5
// ==========================================================
// synchronised pin positions
`define PIN_ENABLE 0
`define PIN_START 1
`define PIN_BRAKE_SEL 2
`define PIN_PFAULT 3
`define PIN_POLE 4
`define PIN_FB_SEL 5
`define PIN_INDEX 6
`define PIN_REF 7
`define PIN_W 8
// ==========================================================
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// file: pin_sync.v
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser for asynchronous pins
module pin_sync #(
	parameter WIDTH = 1
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] pin,
	output reg [WIDTH-1:0] level
);
	reg [WIDTH-1:0] meta; // first stage, read only by the second

	// the first stage may go metastable; nothing else looks at it
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta <= {WIDTH{1'b0}};
			level <= {WIDTH{1'b0}};
		end else begin
			meta <= pin;
			level <= meta;
		end
	end
endmodule // pin_sync

// file: spindle_commutation_ctrl.v
// Operation
// R1: enable high runs commutation and speed loop
// R2: brake: uppers off, lowers on
// R3: fault with brake select low brakes at once
// R4: fault with brake select high: all off
// R5: sample count-down counter once per revolution
// R6: divider 24 for 8-pole, 12 for 4-pole
// R7: feedback select picks index or internal revolution
// R8: sense output toggles per back-EMF advance
// R9: fault output pulled low on supply fault
// R10: host supplies 2 MHz reference clock
// R11: nominal target speed is 3600 rpm
// R12: host starts motor with start pulses
// R13: optional delay after back-EMF commutation instant
// R14: start rising edge advances state once
// R15: back-EMF clocks ignored while start high
// R16: enable low: reference gated, braking applied
// R17: lock output low while speed in range
// R18: six commutation states in fixed order
`timescale 1ns/1ps
`include "spindle_ctrl_map.vh"
module spindle_commutation_ctrl (
	input wire aclk,
	input wire aresetn,
	// axi4-lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// device pins
	input wire enable,
	input wire start,
	input wire brake_select,
	input wire power_fault,
	input wire pole_select,
	input wire feedback_select,
	input wire revolution_index,
	input wire speed_reference_clock,
	input wire [2:0] back_emf_inputs,
	output reg [2:0] upper_predrivers,
	output reg [2:0] lower_predrivers,
	output reg commutation_sense_toggle,
	output reg fault_out,
	output reg fault_oe,
	output reg lock_out,
	output reg lock_oe,
	output reg irq
);
	// ==========================================================
	// constants
	localparam [31:0] SPEED_COUNT_FULL = (`REF_HZ * `SEC_PER_MIN) / `TARGET_RPM;
	localparam [15:0] SPEED_COUNT_RST = SPEED_COUNT_FULL[15:0];
	localparam [2:0] ST0 = 3'd0;
	localparam [2:0] ST1 = 3'd1;
	localparam [2:0] ST2 = 3'd2;
	localparam [2:0] ST3 = 3'd3;
	localparam [2:0] ST4 = 3'd4;
	localparam [2:0] ST5 = 3'd5;
	localparam [16:0] CNT_FLOOR = 17'h1_0000; // most negative count

	// ==========================================================
	// pin synchronisers
	wire [`PIN_W-1:0] pins_raw;
	wire [`PIN_W-1:0] pins; // synchronised levels
	wire [2:0] emf_lvl; // synchronised back-emf comparators
	reg [`PIN_W-1:0] pins_d; // previous levels for edge detection
	reg [2:0] emf_prev;

	assign pins_raw = {speed_reference_clock, revolution_index, feedback_select,
		pole_select, power_fault, brake_select, start, enable};

	pin_sync #(.WIDTH(`PIN_W)) u_sync_pins (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(pins_raw),
		.level(pins)
	);

	pin_sync #(.WIDTH(3)) u_sync_emf (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(back_emf_inputs),
		.level(emf_lvl)
	);

	wire en = pins[`PIN_ENABLE];
	wire start_lvl = pins[`PIN_START];
	wire start_rise = start_lvl & ~pins_d[`PIN_START];
	wire fault_lvl = pins[`PIN_PFAULT];
	wire brake_sel_hi = pins[`PIN_BRAKE_SEL]; // above threshold
	// reference gated off while disabled, saving the counter's power
	wire ref_tick = en & pins[`PIN_REF] & ~pins_d[`PIN_REF]; // R16 R10
	wire index_rise = pins[`PIN_INDEX] & ~pins_d[`PIN_INDEX];
	// any comparator change is a back-emf commutation instant
	wire emf_evt = en & ~start_lvl & (emf_lvl != emf_prev); // R1 R15

	// ==========================================================
	// software registers
	reg [15:0] speed_count; // reference ticks per revolution
	reg [15:0] delay_cycles; // commutation delay, 0 means none
	reg [15:0] lock_win; // allowed error in reference ticks
	reg [`IRQ_W-1:0] int_status;
	reg [`IRQ_W-1:0] int_enable;

	// ==========================================================
	// commutation state
	reg [2:0] comm_state;
	reg [15:0] delay_cnt;
	reg delay_pend;
	reg [4:0] comm_div_cnt;
	reg signed [16:0] down_cnt;
	reg signed [16:0] speed_err;
	reg locked;
	reg braking_q;
	reg fault_q;

	wire delay_done = delay_pend & (delay_cnt == 16'h0001);
	wire emf_now = emf_evt & (delay_cycles == 16'h0000);
	// one step even when start and a delayed step coincide
	wire advance = start_rise | emf_now | delay_done; // R14 R13
	wire [4:0] div_top = pins[`PIN_POLE] ? `DIV_8POLE : `DIV_4POLE; // R6
	wire int_rev = advance & (comm_div_cnt == div_top - 5'd1);
	wire rev_evt = pins[`PIN_FB_SEL] ? index_rise : int_rev; // R7
	wire [16:0] err_abs = down_cnt[16] ? (~down_cnt + 17'd1) : down_cnt; // fresh residual
	wire in_range = (err_abs <= {1'b0, lock_win});
	wire brake_now = ~en | (fault_lvl & ~brake_sel_hi); // R16 R3 R4
	wire free_spin = en & fault_lvl & brake_sel_hi; // R4

	// ==========================================================
	// edge history
	always @(posedge aclk) begin
		if (!aresetn) begin
			pins_d <= {`PIN_W{1'b0}};
			emf_prev <= 3'b000;
		end else begin
			pins_d <= pins;
			emf_prev <= emf_lvl;
		end
	end

	// ==========================================================
	// commutation counter, delay and revolution divider
	always @(posedge aclk) begin
		if (!aresetn) begin
			comm_state <= ST0;
			delay_cnt <= 16'h0000;
			delay_pend <= 1'b0;
			comm_div_cnt <= 5'd0;
			commutation_sense_toggle <= 1'b0;
		end else begin
			// a new instant restarts any pending delay
			if (emf_evt && delay_cycles != 16'h0000) begin
				delay_pend <= 1'b1; // R13
				delay_cnt <= delay_cycles;
			end else if (delay_done || !en) begin
				delay_pend <= 1'b0;
			end else if (delay_pend) begin
				delay_cnt <= delay_cnt - 16'h0001;
			end
			if (emf_evt)
				commutation_sense_toggle <= ~commutation_sense_toggle; // R8
			if (advance) begin
				// fixed six-step order
				if (comm_state == ST5)
					comm_state <= ST0; // R18
				else
					comm_state <= comm_state + 3'd1;
				if (int_rev)
					comm_div_cnt <= 5'd0;
				else
					comm_div_cnt <= comm_div_cnt + 5'd1;
			end
		end
	end

	// ==========================================================
	// count-down speed measurement and lock
	always @(posedge aclk) begin
		if (!aresetn) begin
			down_cnt <= {1'b0, SPEED_COUNT_RST};
			speed_err <= 17'sd0;
			locked <= 1'b0;
		end else if (!en) begin
			// low power: counter parked at target, no lock claimed
			down_cnt <= {1'b0, speed_count};
			locked <= 1'b0;
		end else if (rev_evt) begin
			// residual count is the error: positive means too fast
			speed_err <= down_cnt; // R5 R11
			down_cnt <= {1'b0, speed_count};
			locked <= in_range; // R17
		end else if (ref_tick && down_cnt != CNT_FLOOR) begin
			down_cnt <= down_cnt - 17'sd1; // saturates when stalled
		end
	end

	// ==========================================================
	// predriver outputs and open-drain indicators
	always @(posedge aclk) begin
		if (!aresetn) begin
			upper_predrivers <= 3'b000;
			lower_predrivers <= 3'b111;
			braking_q <= 1'b1;
			fault_q <= 1'b0;
			fault_out <= 1'b0;
			fault_oe <= 1'b0;
			lock_out <= 1'b0;
			lock_oe <= 1'b0;
		end else begin
			braking_q <= brake_now;
			fault_q <= fault_lvl;
			fault_out <= 1'b0;
			fault_oe <= fault_lvl; // R9
			lock_out <= 1'b0;
			lock_oe <= locked & en; // R17
			if (brake_now) begin
				upper_predrivers <= 3'b000; // R2
				lower_predrivers <= 3'b111;
			end else if (free_spin) begin
				upper_predrivers <= 3'b000; // R4
				lower_predrivers <= 3'b000;
			end else begin
				// one upper and one lower phase per state
				case (comm_state) // R18 R1
					ST0: begin
						upper_predrivers <= 3'b001;
						lower_predrivers <= 3'b010;
					end
					ST1: begin
						upper_predrivers <= 3'b001;
						lower_predrivers <= 3'b100;
					end
					ST2: begin
						upper_predrivers <= 3'b010;
						lower_predrivers <= 3'b100;
					end
					ST3: begin
						upper_predrivers <= 3'b010;
						lower_predrivers <= 3'b001;
					end
					ST4: begin
						upper_predrivers <= 3'b100;
						lower_predrivers <= 3'b001;
					end
					ST5: begin
						upper_predrivers <= 3'b100;
						lower_predrivers <= 3'b010;
					end
					default: begin
						upper_predrivers <= 3'b000;
						lower_predrivers <= 3'b000;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// axi4-lite slave
	reg [7:0] aw_addr;
	reg aw_got;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_got;
	wire do_write = aw_got & w_got & ~s_axi_bvalid;
	wire [`IRQ_W-1:0] clear_hit;
	wire [`IRQ_W-1:0] events;

	// byte-lane merge of write data into an old value
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge16 = old;
			if (strb[0])
				merge16[7:0] = data[7:0];
			if (strb[1])
				merge16[15:8] = data[15:8];
		end
	endfunction

	assign clear_hit = (do_write && aw_addr == `OFS_INT_CLEAR && w_strb[0]) ?
		w_data[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
	assign events = {brake_now & ~braking_q, rev_evt, fault_lvl & ~fault_q,
		locked & en & ~in_range & rev_evt, ~locked & in_range & rev_evt & en};

	// channel acceptance and write response
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			speed_count <= SPEED_COUNT_RST;
			delay_cycles <= `DELAY_RST;
			lock_win <= `LOCK_WIN_RST;
			int_enable <= `INT_ENABLE_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_got <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_got <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (aw_addr)
					`OFS_SPEED_COUNT: speed_count <= merge16(speed_count, w_data, w_strb);
					`OFS_DELAY: delay_cycles <= merge16(delay_cycles, w_data, w_strb);
					`OFS_LOCK_WIN: lock_win <= merge16(lock_win, w_data, w_strb);
					`OFS_INT_ENABLE: begin
						if (w_strb[0])
							int_enable <= w_data[`IRQ_W-1:0];
					end
					`OFS_INT_CLEAR: begin
						// handled beside the status bits
					end
					default: s_axi_bresp <= `RESP_SLVERR; // read-only or unmapped
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// sticky interrupt bits; a set in the clear cycle wins
	always @(posedge aclk) begin
		if (!aresetn) begin
			int_status <= {`IRQ_W{1'b0}};
			irq <= 1'b0;
		end else begin
			int_status <= (int_status & ~clear_hit) | events;
			irq <= |(((int_status & ~clear_hit) | events) & int_enable);
		end
	end

	// read channel: data one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (s_axi_araddr)
					`OFS_SPEED_COUNT: s_axi_rdata <= {16'h0000, speed_count};
					`OFS_DELAY: s_axi_rdata <= {16'h0000, delay_cycles};
					`OFS_LOCK_WIN: s_axi_rdata <= {16'h0000, lock_win};
					`OFS_STATUS: s_axi_rdata <= {24'h00_0000, commutation_sense_toggle,
						fault_lvl, locked, free_spin, braking_q, comm_state};
					`OFS_SPEED_ERR: s_axi_rdata <= {{15{speed_err[16]}}, speed_err};
					`OFS_INT_STATUS: s_axi_rdata <= {27'h000_0000, int_status};
					`OFS_INT_ENABLE: s_axi_rdata <= {27'h000_0000, int_enable};
					`OFS_INT_CLEAR: s_axi_rdata <= 32'h0000_0000; // write-only
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // spindle_commutation_ctrl

// file: motor_model.sv
`timescale 1ns/1ps
// ==========================================================
// back-emf comparator model of the spinning motor
module motor_model (
	input wire aclk,
	input wire step,
	output wire [2:0] back_emf_inputs
);
	logic [2:0] ph = 3'h0; // electrical phase 0..5
	// one phase per request, so each request is one sensed instant
	always @(posedge aclk) begin
		if (step) begin
			ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
		end
	end
	// gray coding: a step flips one comparator, except the wrap from 5 to 0, which flips all three
	assign back_emf_inputs = ph ^ (ph >> 1);
endmodule // motor_model

// file: spindle_ctrl_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// pin-side checker; pin figures allow for the two-flop synchroniser
module spindle_ctrl_chk (
	input wire aclk,
	input wire aresetn,
	input wire enable,
	input wire start,
	input wire brake_select,
	input wire power_fault,
	input wire [2:0] upper_predrivers,
	input wire [2:0] lower_predrivers,
	input wire commutation_sense_toggle,
	input wire fault_out,
	input wire fault_oe,
	input wire lock_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire [5:0] drv = {upper_predrivers, lower_predrivers}; // whole drive pattern
	wire [2:0] up = upper_predrivers;
	wire [2:0] lw = lower_predrivers;
	// ==========================================================
	// braking and free spin
	AST_BRAKE: assert property ((!enable)[*4] |=> up == 3'h0 && lw == 3'h7)
		else $error("no brake pattern with enable low");
	AST_FAULT_BRAKE: assert property ((power_fault && !brake_select)[*4] |=> lw == 3'h7 && up == 3'h0)
		else $error("no brake on fault with brake select low");
	AST_FREE_SPIN: assert property ((enable && power_fault && brake_select)[*4] |=> drv == 6'h00)
		else $error("drivers not off in free spin");
	// ==========================================================
	// fault and lock open-drain outputs
	AST_FAULT_ON: assert property (power_fault[*4] |=> fault_oe && !fault_out)
		else $error("fault output not pulled low");
	AST_FAULT_OFF: assert property ((!power_fault)[*4] |=> !fault_oe)
		else $error("fault output not released");
	AST_LOCK_OFF: assert property ((!enable)[*4] |=> !lock_oe)
		else $error("lock held with enable low");
	// ==========================================================
	// commutation
	AST_ONE_HOT: assert property (up != 3'h0 |-> $onehot(up) && $onehot(lw) && (up & lw) == 3'h0)
		else $error("illegal commutation pattern");
	AST_START_STEP: assert property ($rose(start) && enable && $past(enable, 4)
		&& !power_fault && !$past(power_fault, 4) |-> ##[3:6] $changed(drv))
		else $error("start edge did not advance drive");
	AST_START_BLOCK: assert property (start[*8] |=> $stable(commutation_sense_toggle))
		else $error("back-emf accepted while start high");
endmodule // spindle_ctrl_chk
bind spindle_commutation_ctrl spindle_ctrl_chk chk_u (.aclk, .aresetn, .enable, .start,
	.brake_select, .power_fault, .upper_predrivers, .lower_predrivers,
	.commutation_sense_toggle, .fault_out, .fault_oe, .lock_oe);

// file: sensorless_spindle_commutation_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "spindle_ctrl_map.vh"
// ==========================================================
// bench: axi master tasks, pin stimulus, one task per scenario
module sensorless_spindle_commutation_ctrl_tb_top;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hF; // whole words only
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, enable = 0, start = 0, brake_select = 0, power_fault = 0;
	logic pole_select = 0, feedback_select = 0, revolution_index = 0, speed_reference_clock = 0;
	logic mstep = 0, et = 0; // motor step request, expected toggle
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic commutation_sense_toggle, fault_out, fault_oe, lock_out, lock_oe;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [2:0] back_emf_inputs, upper_predrivers, lower_predrivers;
	logic [2:0] eu [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4}; // upper per state
	logic [2:0] el [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2}; // lower per state
	int fail_count = 0, checks_done = 0, st = 0, n;
	spindle_commutation_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enable, .start, .brake_select,
		.power_fault, .pole_select, .feedback_select, .revolution_index, .speed_reference_clock,
		.back_emf_inputs, .upper_predrivers, .lower_predrivers, .commutation_sense_toggle,
		.fault_out, .fault_oe, .lock_out, .lock_oe, .irq);
	motor_model motor_u (.aclk, .step(mstep), .back_emf_inputs);
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	// ==========================================================
	// common tasks
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pd(input logic [2:0] u, input logic [2:0] l);
		chk("upper_predrivers", u, upper_predrivers);
		chk("lower_predrivers", l, lower_predrivers);
	endtask
	// axi write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (!s_axi_bvalid) @(posedge aclk);
		rr = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// host start pulse, wide enough for the synchroniser
	task automatic stp;
		@(posedge aclk) start <= 1;
		cyc(4);
		start <= 0;
		cyc(6);
		st = (st + 1) % 6;
	endtask
	task automatic mv;
		@(posedge aclk) mstep <= 1;
		@(posedge aclk) mstep <= 0;
		cyc(8);
	endtask
	// index-to-index window with exactly five reference edges at 2 mhz
	task automatic meas;
		for (int k = 0; k < 2; k++) begin
			@(posedge aclk) revolution_index <= 1;
			cyc(4);
			revolution_index <= 0;
			cyc(4);
			if (k == 0) repeat (5) begin
				@(posedge aclk) speed_reference_clock <= 1;
				cyc(50);
				speed_reference_clock <= 0;
				cyc(49);
			end
		end
		rd(`OFS_SPEED_ERR);
		chk("speed_err", 32'h0000_000F, rv);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs;
		logic [7:0] ra [5] = '{`OFS_SPEED_COUNT, `OFS_DELAY, `OFS_LOCK_WIN, `OFS_INT_ENABLE, 8'h40};
		logic [31:0] rx [5] = '{32'h0000_8235, 32'h0000_0000, 32'h0000_0037, 32'h0, 32'h0};
		for (int i = 0; i < 5; i++) begin
			rd(ra[i]);
			chk("rdata", rx[i], rv);
			chk("rresp", (i == 4) ? `RESP_SLVERR : `RESP_OKAY, rr);
		end
		wr(`OFS_STATUS, 32'h0000_0001);
		chk("bresp", `RESP_SLVERR, rr);
	endtask
	task automatic t_comm;
		enable <= 1;
		cyc(6);
		pd(eu[0], el[0]);
		for (int i = 1; i < 7; i++) begin
			stp();
			pd(eu[i % 6], el[i % 6]);
		end
	endtask
	task automatic t_emf;
		mv();
		et = ~et;
		chk("toggle", et, commutation_sense_toggle);
		st = 1;
		pd(eu[st], el[st]);
		@(posedge aclk) start <= 1;
		cyc(4);
		mv();
		chk("toggle", et, commutation_sense_toggle);
		st = 2;
		pd(eu[st], el[st]);
		start <= 0;
		cyc(6);
		wr(`OFS_DELAY, 32'h0000_0028);
		mv();
		et = ~et;
		chk("toggle", et, commutation_sense_toggle);
		pd(eu[st], el[st]);
		cyc(40);
		st = 3;
		pd(eu[st], el[st]);
		wr(`OFS_DELAY, 32'h0000_0000);
	endtask
	task automatic t_fault;
		power_fault <= 1;
		cyc(6);
		pd(3'h0, 3'h7);
		chk("fault_oe", 1, fault_oe);
		chk("fault_out", 0, fault_out);
		chk("irq", 0, irq);
		power_fault <= 0;
		brake_select <= 1;
		cyc(6);
		power_fault <= 1;
		cyc(6);
		pd(3'h0, 3'h0);
		brake_select <= 0;
		cyc(6);
		pd(3'h0, 3'h7);
		wr(`OFS_INT_ENABLE, 1 << `IRQ_FAULT);
		cyc(2);
		chk("irq", 1, irq);
		rd(`OFS_INT_STATUS);
		chk("fault_status", 1, rv[`IRQ_FAULT]);
		power_fault <= 0;
		cyc(6);
		chk("fault_oe", 0, fault_oe);
		pd(eu[st], el[st]);
		wr(`OFS_INT_CLEAR, 32'h0000_001F);
		cyc(2);
		chk("irq", 0, irq);
	endtask
	task automatic t_rev;
		for (int p = 0; p < 2; p++) begin
			pole_select <= p[0];
			for (int k = 0; k < 2; k++) begin
				wr(`OFS_INT_CLEAR, 1 << `IRQ_REV);
				n = 0;
				do begin
					stp();
					rd(`OFS_INT_STATUS);
					n++;
				end while (!rv[`IRQ_REV] && n < 30);
			end
			chk("rev_steps", p ? `DIV_8POLE : `DIV_4POLE, n);
		end
	endtask
	task automatic t_speed;
		feedback_select <= 1;
		wr(`OFS_SPEED_COUNT, 32'h0000_0014);
		meas();
		chk("lock_oe", 1, lock_oe);
		chk("lock_out", 0, lock_out);
		enable <= 0;
		cyc(6);
		chk("lock_oe", 0, lock_oe);
		pd(3'h0, 3'h7);
		stp();
		rd(`OFS_STATUS);
		chk("state", st, rv[2:0]);
		enable <= 1;
		wr(`OFS_LOCK_WIN, 32'h0000_0003);
		meas();
		chk("lock_oe", 0, lock_oe);
	endtask
	// ==========================================================
	// verdict and run control
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		cyc(5);
		aresetn <= 1;
		cyc(2);
		pd(3'h0, 3'h7);
		t_regs();
		t_comm();
		t_emf();
		t_fault();
		t_rev();
		t_speed();
		finish_test();
	end
	// watchdog well beyond the few thousand cycles the run needs
	initial begin
		cyc(20000);
		fail_count++;
		finish_test();
	end
endmodule // sensorless_spindle_commutation_ctrl_tb_top
